// ===== hdl/bslf_framer.sv
// How it works
// R1 - top bits 101 mark a flag byte
// R2 - each byte is message or flag
// R3 - flag values never sent unescaped in content
// R4 - message carries at least one byte
// R5 - ident request A0, ident ack A1
// R6 - phase one request A6, release A7
// R7 - phase two A8, A9, reboot AA
// R8 - link error flag is AB
// R9 - start AC, end AD, escape AE
// R10 - AF is padding, anywhere in stream
// R11 - reserved flag codes carry no function
// R12 - escape precedes flag-like byte, bit7 flipped
// R13 - flag during escape handled, escape carries on
// R14 - start or ident request cancels escape
// R15 - unit is start, bytes, end
// R16 - master sets up and ends session
// R17 - master phase one release then request
// R18 - master phase two, optional reboot
// R19 - master ident request, collects ident unit
// R20 - master terminates phase two then one
// R21 - master may hold target reset low
// R22 - padding dropped, no state change
// R23 - ident unit: ack, bytes, end, unmixed
// R24 - echo phase two request once agent ready
// R25 - single pending-escape bit in decoder
`timescale 1ns/10ps
`default_nettype none
`include "bslf_defs.svh"

module bslf_framer (
	input wire logic CLOCK_IN,
	input wire logic RESETN_IN,
	input wire logic MSG_VALID_IN,
	input wire logic [7:0] MSG_DATA_IN,
	input wire logic MSG_LAST_IN,
	output logic MSG_READY_OUT,
	output logic [7:0] TX_BYTE_OUT,
	output logic TX_VALID_OUT,
	input wire logic TX_READY_IN,
	input wire logic RX_VALID_IN,
	input wire logic [7:0] RX_BYTE_IN,
	output logic [7:0] RX_DATA_OUT,
	output logic RX_DATA_VALID_OUT,
	output logic RX_UNIT_START_OUT,
	output logic RX_UNIT_END_OUT,
	output logic RX_IDENT_START_OUT,
	output logic RX_LINK_ERROR_OUT,
	output logic RX_REBOOT_OUT,
	output logic RX_RESERVED_OUT,
	input wire logic SLAVE_READY_IN,
	output logic LINK_ACTIVE_OUT,
	output logic SESSION_ACTIVE_OUT,
	input wire logic IDENT_WR_IN,
	input wire logic [`BSLF_IDENT_AW-1:0] IDENT_ADDR_IN,
	input wire logic [7:0] IDENT_DATA_IN,
	input wire logic [`BSLF_IDENT_AW:0] IDENT_LEN_IN
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic is_flag(input logic [7:0] b);
		is_flag = (b[7:5] == `BSLF_FLAG_PATTERN); // R1 R2 R3
	endfunction : is_flag

	bslf_pkg::bslf_tx_state_e state;
	bslf_pkg::bslf_tx_state_e next_state;
	bslf_pkg::bslf_rx_event_s rx_ev;
	bslf_pkg::bslf_echo_t echo_pend;
	bslf_pkg::bslf_echo_t echo_due;
	bslf_pkg::bslf_echo_t echo_taken;
	logic esc_pending;
	logic id_pending;
	logic id_take;
	logic link_p1;
	logic link_p2;
	logic hold_valid;
	logic next_hold_valid;
	logic [7:0] hold_data;
	logic hold_last;
	logic consume;
	logic send;
	logic [7:0] send_byte;
	logic slot_free;
	logic echo_ok;
	logic [`BSLF_IDENT_AW-1:0] id_idx;
	logic [`BSLF_IDENT_AW-1:0] next_idx;
	logic [`BSLF_IDENT_AW-1:0] id_last;
	logic [7:0] id_byte;
	logic rx_flag;
	logic [7:0] rx_b;

	assign rx_b = RX_BYTE_IN;
	assign rx_flag = RX_VALID_IN && is_flag(rx_b);

	// ------------------------------------------------------------
	// receive decoder
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			esc_pending <= 1'b0;
		end else if (RX_VALID_IN) begin
			if (!is_flag(rx_b)) begin
				esc_pending <= 1'b0; // R25
			end else if (rx_b == `BSLF_ESCAPE) begin
				esc_pending <= 1'b1; // R25
			end else if (rx_b == `BSLF_START ||
				rx_b == `BSLF_IDENT_REQUEST) begin
				esc_pending <= 1'b0; // R14
			end
			// other flags leave the escape armed R13 R22
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rx_ev <= '0;
		end else begin
			rx_ev.data_valid <= 1'b0;
			rx_ev.unit_start <= 1'b0;
			rx_ev.unit_end <= 1'b0;
			rx_ev.ident_start <= 1'b0;
			rx_ev.link_error <= 1'b0;
			rx_ev.reboot <= 1'b0;
			rx_ev.reserved <= 1'b0;
			if (RX_VALID_IN && !is_flag(rx_b)) begin
				rx_ev.data_valid <= 1'b1;
				rx_ev.data <= esc_pending ? (rx_b ^ `BSLF_MSB_FLIP) :
					rx_b; // R12
			end else if (rx_flag) begin
				case (rx_b)
				`BSLF_START: rx_ev.unit_start <= 1'b1; // R9 R15
				`BSLF_END: rx_ev.unit_end <= 1'b1; // R9
				`BSLF_IDENT_ACK: rx_ev.ident_start <= 1'b1; // R5
				`BSLF_LINK_ERROR: rx_ev.link_error <= 1'b1; // R8
				`BSLF_LINK_P2_REBOOT: rx_ev.reboot <= 1'b1; // R7
				`BSLF_PADDING, `BSLF_ESCAPE, `BSLF_IDENT_REQUEST,
				`BSLF_LINK_P1_REQUEST, `BSLF_LINK_P1_RELEASE,
				`BSLF_LINK_P2_REQUEST, `BSLF_LINK_P2_RELEASE: begin
					rx_ev.reserved <= 1'b0; // R10 R22
				end
				default: rx_ev.reserved <= 1'b1; // R11
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// link state and echoes
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			link_p1 <= 1'b0;
			link_p2 <= 1'b0;
		end else begin
			if (rx_flag && rx_b == `BSLF_LINK_P1_REQUEST) begin
				link_p1 <= 1'b1; // R6
			end
			if (rx_flag && rx_b == `BSLF_LINK_P1_RELEASE) begin
				link_p1 <= 1'b0; // R6
				link_p2 <= 1'b0;
			end
			if (echo_taken[1]) begin
				link_p2 <= 1'b1; // R24
			end
			if (rx_flag && rx_b == `BSLF_LINK_P2_RELEASE) begin
				link_p2 <= 1'b0; // R7
			end
		end
	end

	// set wins over the clear of the same cycle
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			echo_pend <= 4'h0;
		end else begin
			echo_pend <= echo_pend & ~echo_taken;
			if (rx_flag && rx_b == `BSLF_LINK_P1_REQUEST) begin
				echo_pend[3] <= 1'b1; // R6
			end
			if (rx_flag && rx_b == `BSLF_LINK_P1_RELEASE) begin
				echo_pend[2] <= 1'b1; // R6
			end
			if (rx_flag && rx_b == `BSLF_LINK_P2_REQUEST) begin
				echo_pend[1] <= 1'b1; // R7 R24
			end
			if (rx_flag && rx_b == `BSLF_LINK_P2_RELEASE) begin
				echo_pend[0] <= 1'b1; // R7
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			id_pending <= 1'b0;
		end else begin
			if (id_take) begin
				id_pending <= 1'b0;
			end
			if (rx_flag && rx_b == `BSLF_IDENT_REQUEST) begin
				id_pending <= 1'b1; // R5
			end
		end
	end

	// phase two echo waits for the agent to be ready
	assign echo_due = {echo_pend[3], echo_pend[2],
		echo_pend[1] && SLAVE_READY_IN, echo_pend[0]}; // R24

	// ------------------------------------------------------------
	// message holding stage
	// ------------------------------------------------------------
	always_comb begin
		next_hold_valid = hold_valid && !consume;
		if (MSG_VALID_IN && MSG_READY_OUT) begin
			next_hold_valid = 1'b1;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			hold_valid <= 1'b0;
			hold_data <= `BSLF_BYTE_RESET;
			hold_last <= 1'b0;
			MSG_READY_OUT <= 1'b0;
		end else begin
			hold_valid <= next_hold_valid;
			MSG_READY_OUT <= !next_hold_valid;
			if (MSG_VALID_IN && MSG_READY_OUT) begin
				hold_data <= MSG_DATA_IN;
				hold_last <= MSG_LAST_IN;
			end
		end
	end

	// ------------------------------------------------------------
	// transmit sequencer
	// ------------------------------------------------------------
	assign slot_free = !TX_VALID_OUT || TX_READY_IN;
	// echoes never split an escape from its byte
	assign echo_ok = (state == bslf_pkg::TX_IDLE) ||
		(state == bslf_pkg::TX_MSG) || (state == bslf_pkg::TX_ID);

	always_comb begin
		next_state = state;
		send = 1'b0;
		send_byte = `BSLF_BYTE_RESET;
		consume = 1'b0;
		echo_taken = 4'h0;
		id_take = 1'b0;
		next_idx = id_idx;
		if (slot_free && echo_ok && (echo_due != 4'h0)) begin
			send = 1'b1;
			if (echo_due[3]) begin
				send_byte = `BSLF_LINK_P1_REQUEST;
				echo_taken = 4'h8;
			end else if (echo_due[2]) begin
				send_byte = `BSLF_LINK_P1_RELEASE;
				echo_taken = 4'h4;
			end else if (echo_due[1]) begin
				send_byte = `BSLF_LINK_P2_REQUEST;
				echo_taken = 4'h2;
			end else begin
				send_byte = `BSLF_LINK_P2_RELEASE;
				echo_taken = 4'h1;
			end
		end else if (slot_free) begin
			case (state)
			bslf_pkg::TX_IDLE: begin
				// ident unit only between message units R23
				if (id_pending) begin
					send = 1'b1;
					send_byte = `BSLF_IDENT_ACK;
					id_take = 1'b1;
					next_idx = `BSLF_INDEX_RESET;
					next_state = bslf_pkg::TX_ID_RD;
				end else if (hold_valid) begin
					send = 1'b1;
					send_byte = `BSLF_START; // R15
					next_state = bslf_pkg::TX_MSG;
				end
			end
			bslf_pkg::TX_MSG: begin
				if (hold_valid && is_flag(hold_data)) begin
					send = 1'b1;
					send_byte = `BSLF_ESCAPE; // R12
					next_state = bslf_pkg::TX_MSG_ESC;
				end else if (hold_valid) begin
					send = 1'b1;
					send_byte = hold_data;
					consume = 1'b1;
					if (hold_last) begin
						next_state = bslf_pkg::TX_MSG_END;
					end
				end
			end
			bslf_pkg::TX_MSG_ESC: begin
				send = 1'b1;
				send_byte = hold_data ^ `BSLF_MSB_FLIP; // R12
				consume = 1'b1;
				next_state = hold_last ? bslf_pkg::TX_MSG_END :
					bslf_pkg::TX_MSG;
			end
			bslf_pkg::TX_MSG_END: begin
				send = 1'b1;
				send_byte = `BSLF_END; // R15
				next_state = bslf_pkg::TX_IDLE;
			end
			bslf_pkg::TX_ID_RD: begin
				next_state = bslf_pkg::TX_ID;
			end
			bslf_pkg::TX_ID: begin
				send = 1'b1;
				if (is_flag(id_byte)) begin
					send_byte = `BSLF_ESCAPE; // R12 R23
					next_state = bslf_pkg::TX_ID_ESC;
				end else begin
					send_byte = id_byte;
					next_idx = id_idx + 4'h1;
					next_state = (id_idx == id_last) ?
						bslf_pkg::TX_MSG_END : bslf_pkg::TX_ID_RD;
				end
			end
			bslf_pkg::TX_ID_ESC: begin
				send = 1'b1;
				send_byte = id_byte ^ `BSLF_MSB_FLIP; // R12
				next_idx = id_idx + 4'h1;
				next_state = (id_idx == id_last) ?
					bslf_pkg::TX_MSG_END : bslf_pkg::TX_ID_RD;
			end
			default: next_state = bslf_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state <= bslf_pkg::TX_IDLE;
			id_idx <= `BSLF_INDEX_RESET;
		end else begin
			state <= next_state;
			id_idx <= next_idx;
		end
	end

	// a zero length still sends one ident byte R4 R23
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			id_last <= `BSLF_INDEX_RESET;
		end else if (id_take) begin
			id_last <= (IDENT_LEN_IN == 5'h00) ? 4'h0 :
				IDENT_LEN_IN[`BSLF_IDENT_AW-1:0] - 4'h1;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			TX_VALID_OUT <= 1'b0;
			TX_BYTE_OUT <= `BSLF_BYTE_RESET;
		end else if (send) begin
			TX_VALID_OUT <= 1'b1;
			TX_BYTE_OUT <= send_byte;
		end else if (TX_READY_IN) begin
			TX_VALID_OUT <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// identification store and outputs
	// ------------------------------------------------------------
	bslf_ident_mem u_ident_mem (
		.clk_in(CLOCK_IN),
		.wr_en_in(IDENT_WR_IN),
		.wr_addr_in(IDENT_ADDR_IN),
		.wr_data_in(IDENT_DATA_IN),
		.rd_addr_in(id_idx),
		.rd_data_out(id_byte)
	);

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			LINK_ACTIVE_OUT <= 1'b0;
			SESSION_ACTIVE_OUT <= 1'b0;
		end else begin
			LINK_ACTIVE_OUT <= link_p1;
			SESSION_ACTIVE_OUT <= link_p2;
		end
	end

	assign RX_DATA_OUT = rx_ev.data;
	assign RX_DATA_VALID_OUT = rx_ev.data_valid;
	assign RX_UNIT_START_OUT = rx_ev.unit_start;
	assign RX_UNIT_END_OUT = rx_ev.unit_end;
	assign RX_IDENT_START_OUT = rx_ev.ident_start;
	assign RX_LINK_ERROR_OUT = rx_ev.link_error;
	assign RX_REBOOT_OUT = rx_ev.reboot;
	assign RX_RESERVED_OUT = rx_ev.reserved;

endmodule : bslf_framer

`default_nettype wire

// ===== hdl/bslf_defs.svh
`ifndef BSLF_DEFS_SVH
`define BSLF_DEFS_SVH

// ----------------------------------------------------------------
// flag classification
// ----------------------------------------------------------------
`define BSLF_FLAG_PATTERN 3'h5
`define BSLF_MSB_FLIP 8'h80

// ----------------------------------------------------------------
// flag codes
// ----------------------------------------------------------------
`define BSLF_IDENT_REQUEST 8'hA0
`define BSLF_IDENT_ACK 8'hA1
`define BSLF_LINK_P1_REQUEST 8'hA6
`define BSLF_LINK_P1_RELEASE 8'hA7
`define BSLF_LINK_P2_REQUEST 8'hA8
`define BSLF_LINK_P2_RELEASE 8'hA9
`define BSLF_LINK_P2_REBOOT 8'hAA
`define BSLF_LINK_ERROR 8'hAB
`define BSLF_START 8'hAC
`define BSLF_END 8'hAD
`define BSLF_ESCAPE 8'hAE
`define BSLF_PADDING 8'hAF

// ----------------------------------------------------------------
// identification store
// ----------------------------------------------------------------
`define BSLF_IDENT_DEPTH 16
`define BSLF_IDENT_AW 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BSLF_BYTE_RESET 8'h00
`define BSLF_INDEX_RESET 4'h0

`endif

// ===== hdl/bslf_pkg.sv
package bslf_pkg;

	// ------------------------------------------------------------
	// transmit sequencer states
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		TX_IDLE = 7'h01,
		TX_MSG = 7'h02,
		TX_MSG_ESC = 7'h04,
		TX_MSG_END = 7'h08,
		TX_ID_RD = 7'h10,
		TX_ID = 7'h20,
		TX_ID_ESC = 7'h40
	} bslf_tx_state_e;

	// ------------------------------------------------------------
	// receive event bundle
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic data_valid;
		logic unit_start;
		logic unit_end;
		logic ident_start;
		logic link_error;
		logic reboot;
		logic reserved;
	} bslf_rx_event_s;

	// pending echoes: p1 request, p1 release, p2 request, p2 release
	typedef logic [3:0] bslf_echo_t;

endpackage : bslf_pkg

// ===== hdl/bslf_ident_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "bslf_defs.svh"

module bslf_ident_mem (
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [`BSLF_IDENT_AW-1:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [`BSLF_IDENT_AW-1:0] rd_addr_in,
	output logic [7:0] rd_data_out
);

	logic [7:0] mem [0:`BSLF_IDENT_DEPTH-1];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// registered read: data trails the address by one edge
	always_ff @(posedge clk_in) begin
		rd_data_out <= mem[rd_addr_in];
	end

endmodule : bslf_ident_mem

`default_nettype wire

// ===== hdl/bslf_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== testbench/bslf_link_partner.sv
`timescale 1ns/10ps
`default_nettype none

module bslf_link_partner (
	input wire logic clk_in,
	input wire logic slow_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out
);
	logic [7:0] got [$];
	logic [1:0] phase;

	initial begin
		tx_ready_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
		phase = 2'h0;
	end

	// slow mode takes one byte in four, so the sender must hold its byte
	always @(negedge clk_in) begin
		phase <= phase + 2'h1;
		tx_ready_out <= !slow_in || phase == 2'h0;
	end

	always @(posedge clk_in) begin
		if (tx_valid_in && tx_ready_out)
			got.push_back(tx_byte_in);
	end

	// whole bytes only, one per cycle when called back to back
	task automatic send(input logic [7:0] b);
		@(negedge clk_in);
		rx_valid_out = 1'b1;
		rx_byte_out = b;
	endtask : send

	// idle line shows the inverse, never a stale copy of the last byte
	task automatic quiet;
		@(negedge clk_in);
		rx_valid_out = 1'b0;
		rx_byte_out = ~rx_byte_out;
	endtask : quiet
endmodule : bslf_link_partner
`default_nettype wire

// ===== testbench/bslf_framer_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "bslf_defs.svh"

module bslf_framer_checker (
	input wire logic CLOCK_IN,
	input wire logic RESETN_IN,
	input wire logic [7:0] TX_BYTE_OUT,
	input wire logic TX_VALID_OUT,
	input wire logic TX_READY_IN,
	input wire logic RX_VALID_IN,
	input wire logic [7:0] RX_BYTE_IN,
	input wire logic [7:0] RX_DATA_OUT,
	input wire logic RX_DATA_VALID_OUT,
	input wire logic RX_UNIT_START_OUT,
	input wire logic RX_UNIT_END_OUT,
	input wire logic RX_IDENT_START_OUT,
	input wire logic RX_LINK_ERROR_OUT,
	input wire logic RX_REBOOT_OUT,
	input wire logic RX_RESERVED_OUT
);
	logic esc_pend;
	logic tx_after_esc;
	logic rx_flag;

	assign rx_flag = RX_BYTE_IN[7:5] == `BSLF_FLAG_PATTERN;

	// ------------------------------------------------------------
	// reference escape state
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			esc_pend <= 1'b0;
		else if (RX_VALID_IN && RX_BYTE_IN == `BSLF_ESCAPE)
			esc_pend <= 1'b1;
		else if (RX_VALID_IN && (!rx_flag || RX_BYTE_IN == `BSLF_START ||
			RX_BYTE_IN == `BSLF_IDENT_REQUEST))
			esc_pend <= 1'b0;
	end

	always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			tx_after_esc <= 1'b0;
		else if (TX_VALID_OUT && TX_READY_IN)
			tx_after_esc <= TX_BYTE_OUT == `BSLF_ESCAPE;
	end

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RESETN_IN);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	plain_data_a: assert property (
		RX_VALID_IN && !rx_flag && !esc_pend |=>
		RX_DATA_VALID_OUT && RX_DATA_OUT == $past(RX_BYTE_IN))
		else $error("plain byte not delivered");
	escaped_data_a: assert property (
		RX_VALID_IN && !rx_flag && esc_pend |=> RX_DATA_VALID_OUT &&
		RX_DATA_OUT == ($past(RX_BYTE_IN) ^ `BSLF_MSB_FLIP))
		else $error("escaped byte not restored");
	flag_no_data_a: assert property (
		RX_VALID_IN && rx_flag |=> !RX_DATA_VALID_OUT)
		else $error("flag delivered as data");
	frame_flags_a: assert property (
		RX_VALID_IN && RX_BYTE_IN[7:1] == 7'h56 |=>
		RX_UNIT_START_OUT != RX_UNIT_END_OUT &&
		RX_UNIT_END_OUT == $past(RX_BYTE_IN[0]))
		else $error("frame flag event wrong");
	ident_ack_a: assert property (
		RX_VALID_IN && RX_BYTE_IN == `BSLF_IDENT_ACK |=> RX_IDENT_START_OUT)
		else $error("ident start missing");
	error_reboot_a: assert property (
		RX_VALID_IN && RX_BYTE_IN[7:1] == 7'h55 |=>
		RX_LINK_ERROR_OUT == $past(RX_BYTE_IN[0]) &&
		RX_REBOOT_OUT == !$past(RX_BYTE_IN[0]))
		else $error("link error or reboot event wrong");
	reserved_code_a: assert property (
		RX_VALID_IN && RX_BYTE_IN inside {[8'hA2:8'hA5], [8'hB0:8'hBF]}
		|=> RX_RESERVED_OUT && !RX_DATA_VALID_OUT)
		else $error("reserved code not reported");
	padding_silent_a: assert property (
		RX_VALID_IN && RX_BYTE_IN == `BSLF_PADDING |=>
		!(RX_DATA_VALID_OUT || RX_UNIT_START_OUT || RX_UNIT_END_OUT ||
		RX_IDENT_START_OUT || RX_LINK_ERROR_OUT || RX_REBOOT_OUT ||
		RX_RESERVED_OUT))
		else $error("padding produced an event");
	tx_hold_a: assert property (
		TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_BYTE_OUT))
		else $error("transmit byte dropped before taken");
	tx_escape_pair_a: assert property (
		TX_VALID_OUT && tx_after_esc |-> TX_BYTE_OUT[7:5] != `BSLF_FLAG_PATTERN)
		else $error("flag sent after escape");
endmodule : bslf_framer_checker

bind bslf_framer bslf_framer_checker bslf_framer_checker_i (
	.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN), .TX_BYTE_OUT(TX_BYTE_OUT),
	.TX_VALID_OUT(TX_VALID_OUT), .TX_READY_IN(TX_READY_IN),
	.RX_VALID_IN(RX_VALID_IN), .RX_BYTE_IN(RX_BYTE_IN),
	.RX_DATA_OUT(RX_DATA_OUT), .RX_DATA_VALID_OUT(RX_DATA_VALID_OUT),
	.RX_UNIT_START_OUT(RX_UNIT_START_OUT), .RX_UNIT_END_OUT(RX_UNIT_END_OUT),
	.RX_IDENT_START_OUT(RX_IDENT_START_OUT),
	.RX_LINK_ERROR_OUT(RX_LINK_ERROR_OUT), .RX_REBOOT_OUT(RX_REBOOT_OUT),
	.RX_RESERVED_OUT(RX_RESERVED_OUT)
);
`default_nettype wire

// ===== testbench/bslf_framer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module bslf_framer_tb_top;
	logic clk, rst_n, msg_valid, msg_last, msg_ready, tx_valid, tx_ready;
	logic rx_valid, rx_dv, rx_start, rx_end, rx_ident, rx_err, rx_reboot;
	logic rx_res, slave_ready, link_active, session_active, id_wr, slow;
	logic [7:0] msg_data, tx_byte, rx_byte, rx_data, id_data;
	logic [3:0] id_addr;
	logic [4:0] id_len;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	// rx byte, then expected data and valid, start, end, ident, err, reboot,
	// reserved; order matters because escape state carries between rows
	// the reboot row stands for a reboot sent as a flag, not the pin
	logic [22:0] rows [19] = '{
		{8'hAC, 8'h00, 7'h20}, {8'h41, 8'h41, 7'h40}, {8'hAE, 8'h00, 7'h00},
		{8'hAF, 8'h00, 7'h00}, {8'hAB, 8'h00, 7'h04}, {8'h2C, 8'hAC, 7'h40},
		{8'hAE, 8'h00, 7'h00}, {8'hAC, 8'h00, 7'h20}, {8'h41, 8'h41, 7'h40},
		{8'hAA, 8'h00, 7'h02}, {8'hA1, 8'h00, 7'h08}, {8'hA2, 8'h00, 7'h01},
		{8'hA5, 8'h00, 7'h01}, {8'hB0, 8'h00, 7'h01}, {8'hBF, 8'h00, 7'h01},
		{8'h7F, 8'h7F, 7'h40}, {8'hAE, 8'h00, 7'h00}, {8'hD5, 8'h55, 7'h40},
		{8'hAD, 8'h00, 7'h10}};

	bslf_framer bslf_framer_i (
		.CLOCK_IN(clk), .RESETN_IN(rst_n), .MSG_VALID_IN(msg_valid),
		.MSG_DATA_IN(msg_data), .MSG_LAST_IN(msg_last),
		.MSG_READY_OUT(msg_ready), .TX_BYTE_OUT(tx_byte),
		.TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
		.RX_VALID_IN(rx_valid), .RX_BYTE_IN(rx_byte), .RX_DATA_OUT(rx_data),
		.RX_DATA_VALID_OUT(rx_dv), .RX_UNIT_START_OUT(rx_start),
		.RX_UNIT_END_OUT(rx_end), .RX_IDENT_START_OUT(rx_ident),
		.RX_LINK_ERROR_OUT(rx_err), .RX_REBOOT_OUT(rx_reboot),
		.RX_RESERVED_OUT(rx_res), .SLAVE_READY_IN(slave_ready),
		.LINK_ACTIVE_OUT(link_active), .SESSION_ACTIVE_OUT(session_active),
		.IDENT_WR_IN(id_wr), .IDENT_ADDR_IN(id_addr),
		.IDENT_DATA_IN(id_data), .IDENT_LEN_IN(id_len));

	bslf_link_partner bslf_link_partner_i (
		.clk_in(clk), .slow_in(slow), .tx_byte_in(tx_byte),
		.tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.rx_valid_out(rx_valid), .rx_byte_out(rx_byte));

	// ------------------------------------------------------------
	// clock, timeout and reporting
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ------------------------------------------------------------
	// traffic helpers
	// ------------------------------------------------------------
	// holds the offer until an edge sees ready; caller lowers valid
	task automatic msg_send(input logic [7:0] b, input logic last);
		int n;
		n = 0;
		@(negedge clk);
		msg_valid = 1'b1;
		msg_data = b;
		msg_last = last;
		do begin
			@(posedge clk);
			n++;
		end while (msg_ready !== 1'b1 && n < 200);
	endtask : msg_send

	task automatic expect_tx(input logic [7:0] exp [$]);
		int n;
		n = 0;
		while (bslf_link_partner_i.got.size() < exp.size() && n < 400) begin
			@(negedge clk);
			n++;
		end
		repeat (6) @(negedge clk);
		check(32'(bslf_link_partner_i.got.size()), 32'(exp.size()));
		foreach (exp[i])
			check(32'(bslf_link_partner_i.got[i]), 32'(exp[i]));
		bslf_link_partner_i.got.delete();
	endtask : expect_tx

	task automatic rx_one(input logic [7:0] b);
		bslf_link_partner_i.send(b);
		bslf_link_partner_i.quiet();
	endtask : rx_one

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		msg_valid = 1'b0;
		msg_last = 1'b0;
		msg_data = 8'h00;
		slave_ready = 1'b0;
		id_wr = 1'b0;
		id_addr = 4'h0;
		id_data = 8'h00;
		id_len = 5'h02;
		slow = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check(32'(msg_ready), 32'h1);
		foreach (rows[i]) begin
			rx_one(rows[i][22:15]);
			check(32'({rx_dv ? rx_data : 8'h00, rx_dv, rx_start, rx_end,
				rx_ident, rx_err, rx_reboot, rx_res}), 32'(rows[i][14:0]));
		end
		// session set-up: release, request, then phase two
		rx_one(8'hA7);
		expect_tx('{8'hA7});
		rx_one(8'hA6);
		expect_tx('{8'hA6});
		check(32'(link_active), 32'h1);
		rx_one(8'hA8);
		repeat (10) @(negedge clk);
		check(32'(bslf_link_partner_i.got.size()), 32'h0);
		slave_ready = 1'b1;
		expect_tx('{8'hA8});
		check(32'(session_active), 32'h1);
		// identification with a cancelled escape and a stalling link
		id_wr = 1'b1;
		id_data = 8'h4D;
		@(negedge clk);
		id_addr = 4'h1;
		id_data = 8'hB2;
		@(negedge clk);
		id_wr = 1'b0;
		slow = 1'b1;
		bslf_link_partner_i.send(8'hAE);
		rx_one(8'hA0);
		expect_tx('{8'hA1, 8'h4D, 8'hAE, 8'h32, 8'hAD});
		rx_one(8'h41);
		check(32'({rx_dv, rx_data}), 32'h141);
		// a zero length still names the protocol with one byte
		id_len = 5'h00;
		rx_one(8'hA0);
		expect_tx('{8'hA1, 8'h4D, 8'hAD});
		// two back-to-back messages, the second a single flag-like byte
		msg_send(8'h41, 1'b0);
		msg_send(8'hA3, 1'b0);
		msg_send(8'h7F, 1'b1);
		msg_send(8'hB0, 1'b1);
		@(negedge clk);
		msg_valid = 1'b0;
		expect_tx('{8'hAC, 8'h41, 8'hAE, 8'h23, 8'h7F, 8'hAD,
			8'hAC, 8'hAE, 8'h30, 8'hAD});
		// termination: phase two release, then phase one release
		rx_one(8'hA9);
		expect_tx('{8'hA9});
		check(32'(session_active), 32'h0);
		rx_one(8'hA7);
		expect_tx('{8'hA7});
		check(32'(link_active), 32'h0);
		// reset in mid-run drops link state and the pending echo
		rx_one(8'hA6);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		check(32'({msg_ready, tx_valid, link_active}), 32'h0);
		rst_n = 1'b1;
		bslf_link_partner_i.got.delete();
		msg_send(8'h5A, 1'b1);
		@(negedge clk);
		msg_valid = 1'b0;
		expect_tx('{8'hAC, 8'h5A, 8'hAD});
		report_and_stop();
	end
endmodule : bslf_framer_tb_top
`default_nettype wire
